// file: cesd_pkg.sv
package cesd_pkg;

    localparam logic [7:0] CESD_EV_FP_SIMD = 8'hCC;
    localparam logic [7:0] CESD_EV_DECODE = 8'hD0;
    localparam logic [7:0] CESD_EV_UOPS = 8'hD1;
    localparam logic [7:0] CESD_EV_RENAME = 8'hD2;
    localparam logic [7:0] CESD_EV_SEG_STALL = 8'hD4;
    localparam logic [7:0] CESD_EV_ES_RENAME = 8'hD5;

    localparam logic [7:0] CESD_UM_01 = 8'h01;
    localparam logic [7:0] CESD_UM_02 = 8'h02;
    localparam logic [7:0] CESD_UM_03 = 8'h03;
    localparam logic [7:0] CESD_UM_04 = 8'h04;
    localparam logic [7:0] CESD_UM_08 = 8'h08;
    localparam logic [7:0] CESD_UM_0F = 8'h0F;

    // longest instruction the decoders handle without the sequencer
    localparam int CESD_SEQ_UOP_THRESHOLD = 4;

    typedef enum logic [1:0] {
        CESD_CLASS_NONE,
        CESD_CLASS_FLOAT,
        CESD_CLASS_SIMD
    } cesd_class_t;

    typedef struct packed {
        logic [7:0] event_code;
        logic [7:0] unit_mask;
    } cesd_select_t;

    // per-cycle occurrences from front end and rename stage
    typedef struct packed {
        logic float_inst;
        logic simd_inst;
        logic inst_decoded;
        logic seq_uop;
        logic stack_op_folding;
        logic stack_delta_sync;
        logic flag_stall;
        logic partial_reg_stall;
        logic read_port_stall;
        logic serialization_stall;
        logic fp_status_word_stall;
        logic segment_rename_stall;
        logic extra_segment_rename;
    } cesd_events_t;

endpackage

// file: cesd_selector.sv
`timescale 1ns/1ps
// Behaviour
// - CCH/01H: first float after simd op
// - CCH/02H: first simd after float op
// - CCH/03H: every float/simd transition either way
// - D0H/01H: every decoded instruction counted
// - D1H/02H: sequencer micro-ops counted
// - D1H/04H: folded stack-pointer instructions counted
// - D1H/08H: stack delta sync operations counted
// - D2H/01H: flag stall cycles counted
// - D2H/02H: partial register stall cycles counted
// - D2H/04H: read-port stall cycles, retries recounted
// - D2H/08H: serialization stall cycles counted
// - D2H/0FH: flag, partial register, read-port or FP status word stall cycles counted, not serialization
// - D4H/01H: segment rename stall cycles counted
// - D5H/01H: extra segment renames counted
module cesd_selector (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire cesd_pkg::cesd_select_t sel,
    input wire cesd_pkg::cesd_events_t ev,
    output logic increment
);
    import cesd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // last float/simd class seen

    cesd_class_t last_class_reg;
    cesd_class_t last_class_next;
    logic increment_reg;
    logic increment_next;
    logic to_float;
    logic to_simd;

    // a cycle with both kinds keeps order float then simd
    always_comb begin
        to_float = ev.float_inst && !ev.simd_inst && (last_class_reg == CESD_CLASS_SIMD);
        to_simd = ev.simd_inst && (ev.float_inst || last_class_reg == CESD_CLASS_FLOAT);
        last_class_next = last_class_reg;
        if (ev.simd_inst) begin
            last_class_next = CESD_CLASS_SIMD;
        end else if (ev.float_inst) begin
            last_class_next = CESD_CLASS_FLOAT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event select

    function automatic logic hit(input cesd_select_t s, input logic [7:0] code,
                                 input logic [7:0] mask);
        hit = (s.event_code == code) && (s.unit_mask == mask);
    endfunction

    always_comb begin
        increment_next = 1'b0;
        if (hit(sel, CESD_EV_FP_SIMD, CESD_UM_01)) begin
            increment_next = to_float;
        end else if (hit(sel, CESD_EV_FP_SIMD, CESD_UM_02)) begin
            increment_next = to_simd;
        end else if (hit(sel, CESD_EV_FP_SIMD, CESD_UM_03)) begin
            increment_next = to_float || to_simd;
        end else if (hit(sel, CESD_EV_DECODE, CESD_UM_01)) begin
            increment_next = ev.inst_decoded;
        end else if (hit(sel, CESD_EV_UOPS, CESD_UM_02)) begin
            increment_next = ev.seq_uop;
        end else if (hit(sel, CESD_EV_UOPS, CESD_UM_04)) begin
            increment_next = ev.stack_op_folding;
        end else if (hit(sel, CESD_EV_UOPS, CESD_UM_08)) begin
            increment_next = ev.stack_delta_sync;
        end else if (hit(sel, CESD_EV_RENAME, CESD_UM_01)) begin
            increment_next = ev.flag_stall;
        end else if (hit(sel, CESD_EV_RENAME, CESD_UM_02)) begin
            increment_next = ev.partial_reg_stall;
        end else if (hit(sel, CESD_EV_RENAME, CESD_UM_04)) begin
            increment_next = ev.read_port_stall;
        end else if (hit(sel, CESD_EV_RENAME, CESD_UM_08)) begin
            increment_next = ev.serialization_stall;
        end else if (hit(sel, CESD_EV_RENAME, CESD_UM_0F)) begin
            increment_next = ev.read_port_stall || ev.partial_reg_stall
                || ev.flag_stall || ev.fp_status_word_stall;
        end else if (hit(sel, CESD_EV_SEG_STALL, CESD_UM_01)) begin
            increment_next = ev.segment_rename_stall;
        end else if (hit(sel, CESD_EV_ES_RENAME, CESD_UM_01)) begin
            increment_next = ev.extra_segment_rename;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            last_class_reg <= CESD_CLASS_NONE;
            increment_reg <= 1'b0;
        end else begin
            last_class_reg <= last_class_next;
            increment_reg <= increment_next;
        end
    end

    assign increment = increment_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_float_after_simd;
        last_class_reg == CESD_CLASS_SIMD && ev.float_inst && !ev.simd_inst;
    endsequence

    sequence s_simd_alone;
        ev.simd_inst && !ev.float_inst;
    endsequence

    sequence s_float_alone;
        ev.float_inst && !ev.simd_inst;
    endsequence

    sequence s_simd_then_float;
        s_simd_alone ##1 s_float_alone;
    endsequence

    sequence s_float_then_simd;
        s_float_alone ##1 ev.simd_inst;
    endsequence

    sequence s_float_then_float;
        s_float_alone ##1 s_float_alone;
    endsequence

    sequence s_read_port_stalled;
        hit(sel, CESD_EV_RENAME, CESD_UM_04) && ev.read_port_stall;
    endsequence

    function automatic logic pair_listed(input cesd_select_t s);
        pair_listed = hit(s, CESD_EV_FP_SIMD, CESD_UM_01)
            || hit(s, CESD_EV_FP_SIMD, CESD_UM_02)
            || hit(s, CESD_EV_FP_SIMD, CESD_UM_03)
            || hit(s, CESD_EV_DECODE, CESD_UM_01)
            || hit(s, CESD_EV_UOPS, CESD_UM_02)
            || hit(s, CESD_EV_UOPS, CESD_UM_04)
            || hit(s, CESD_EV_UOPS, CESD_UM_08)
            || hit(s, CESD_EV_RENAME, CESD_UM_01)
            || hit(s, CESD_EV_RENAME, CESD_UM_02)
            || hit(s, CESD_EV_RENAME, CESD_UM_04)
            || hit(s, CESD_EV_RENAME, CESD_UM_08)
            || hit(s, CESD_EV_RENAME, CESD_UM_0F)
            || hit(s, CESD_EV_SEG_STALL, CESD_UM_01)
            || hit(s, CESD_EV_ES_RENAME, CESD_UM_01);
    endfunction

    property p_to_float;
        @(posedge ref_clk) disable iff (!rstn)
        hit(sel, CESD_EV_FP_SIMD, CESD_UM_01) ##0 s_float_after_simd |=> increment;
    endproperty
    a_to_float: assert property (p_to_float) else $error("missed float transition");

    property p_to_simd_once;
        @(posedge ref_clk) disable iff (!rstn)
        (hit(sel, CESD_EV_FP_SIMD, CESD_UM_02) && ev.simd_inst && !ev.float_inst
            && last_class_reg == CESD_CLASS_SIMD) |=> !increment;
    endproperty
    a_to_simd_once: assert property (p_to_simd_once) else $error("simd counted twice");

    property p_any_trans;
        @(posedge ref_clk) disable iff (!rstn)
        hit(sel, CESD_EV_FP_SIMD, CESD_UM_03) |=> increment == $past(to_float || to_simd);
    endproperty
    a_any_trans: assert property (p_any_trans) else $error("transition count wrong");

    property p_decoded;
        @(posedge ref_clk) disable iff (!rstn)
        hit(sel, CESD_EV_DECODE, CESD_UM_01) |=> increment == $past(ev.inst_decoded);
    endproperty
    a_decoded: assert property (p_decoded) else $error("decode count wrong");

    property p_seq_uop;
        @(posedge ref_clk) disable iff (!rstn)
        hit(sel, CESD_EV_UOPS, CESD_UM_02) |=> increment == $past(ev.seq_uop);
    endproperty
    a_seq_uop: assert property (p_seq_uop) else $error("sequencer count wrong");

    property p_sync;
        @(posedge ref_clk) disable iff (!rstn)
        hit(sel, CESD_EV_UOPS, CESD_UM_08) |=> increment == $past(ev.stack_delta_sync);
    endproperty
    a_sync: assert property (p_sync) else $error("sync count wrong");

    property p_read_port_retry;
        @(posedge ref_clk) disable iff (!rstn)
        s_read_port_stalled[*2] |-> increment ##1 increment;
    endproperty
    a_read_port_retry: assert property (p_read_port_retry) else $error("retry not recounted");

    property p_rename_any;
        @(posedge ref_clk) disable iff (!rstn)
        (hit(sel, CESD_EV_RENAME, CESD_UM_0F) && !ev.read_port_stall && !ev.partial_reg_stall
            && !ev.flag_stall && !ev.fp_status_word_stall) |=> !increment;
    endproperty
    a_rename_any: assert property (p_rename_any) else $error("stray rename stall");

    property p_seg_stall;
        @(posedge ref_clk) disable iff (!rstn)
        (hit(sel, CESD_EV_SEG_STALL, CESD_UM_01) && ev.segment_rename_stall) |=> increment;
    endproperty
    a_seg_stall: assert property (p_seg_stall) else $error("segment stall missed");

    property p_unlisted;
        @(posedge ref_clk) disable iff (!rstn)
        (sel.event_code != CESD_EV_FP_SIMD && sel.event_code != CESD_EV_DECODE
            && sel.event_code != CESD_EV_UOPS && sel.event_code != CESD_EV_RENAME
            && sel.event_code != CESD_EV_SEG_STALL && sel.event_code != CESD_EV_ES_RENAME)
            |=> !increment;
    endproperty
    a_unlisted: assert property (p_unlisted) else $error("unlisted event counted");

    property p_simd_to_float;
        @(posedge ref_clk) disable iff (!rstn)
        s_simd_then_float ##0 hit(sel, CESD_EV_FP_SIMD, CESD_UM_01) |=> increment;
    endproperty
    a_simd_to_float: assert property (p_simd_to_float) else $error("missed first float");

    property p_float_repeat;
        @(posedge ref_clk) disable iff (!rstn)
        s_float_then_float ##0 hit(sel, CESD_EV_FP_SIMD, CESD_UM_01) |=> !increment;
    endproperty
    a_float_repeat: assert property (p_float_repeat) else $error("float counted twice");

    property p_both_not_float;
        @(posedge ref_clk) disable iff (!rstn)
        hit(sel, CESD_EV_FP_SIMD, CESD_UM_01) && ev.float_inst && ev.simd_inst |=> !increment;
    endproperty
    a_both_not_float: assert property (p_both_not_float) else $error("both as float");

    property p_float_to_simd;
        @(posedge ref_clk) disable iff (!rstn)
        s_float_then_simd ##0 hit(sel, CESD_EV_FP_SIMD, CESD_UM_02) |=> increment;
    endproperty
    a_float_to_simd: assert property (p_float_to_simd) else $error("missed first simd");

    property p_both_kinds;
        @(posedge ref_clk) disable iff (!rstn)
        hit(sel, CESD_EV_FP_SIMD, CESD_UM_02) && ev.float_inst && ev.simd_inst |=> increment;
    endproperty
    a_both_kinds: assert property (p_both_kinds) else $error("both kinds missed");

    property p_any_to_float;
        @(posedge ref_clk) disable iff (!rstn)
        s_simd_then_float ##0 hit(sel, CESD_EV_FP_SIMD, CESD_UM_03) |=> increment;
    endproperty
    a_any_to_float: assert property (p_any_to_float) else $error("any missed float");

    property p_any_to_simd;
        @(posedge ref_clk) disable iff (!rstn)
        s_float_then_simd ##0 hit(sel, CESD_EV_FP_SIMD, CESD_UM_03) |=> increment;
    endproperty
    a_any_to_simd: assert property (p_any_to_simd) else $error("any missed simd");

    property p_hist_simd;
        @(posedge ref_clk) disable iff (!rstn)
        ev.simd_inst |=> last_class_reg == CESD_CLASS_SIMD;
    endproperty
    a_hist_simd: assert property (p_hist_simd) else $error("simd history lost");

    property p_hist_float;
        @(posedge ref_clk) disable iff (!rstn)
        s_float_alone |=> last_class_reg == CESD_CLASS_FLOAT;
    endproperty
    a_hist_float: assert property (p_hist_float) else $error("float history lost");

    property p_hist_hold;
        @(posedge ref_clk) disable iff (!rstn)
        !ev.float_inst && !ev.simd_inst |=> $stable(last_class_reg);
    endproperty
    a_hist_hold: assert property (p_hist_hold) else $error("history moved when idle");

    property p_fold;
        @(posedge ref_clk) disable iff (!rstn)
        hit(sel, CESD_EV_UOPS, CESD_UM_04) |=> increment == $past(ev.stack_op_folding);
    endproperty
    a_fold: assert property (p_fold) else $error("folding count wrong");

    property p_flag;
        @(posedge ref_clk) disable iff (!rstn)
        hit(sel, CESD_EV_RENAME, CESD_UM_01) |=> increment == $past(ev.flag_stall);
    endproperty
    a_flag: assert property (p_flag) else $error("flag stall count wrong");

    property p_partial;
        @(posedge ref_clk) disable iff (!rstn)
        hit(sel, CESD_EV_RENAME, CESD_UM_02) |=> increment == $past(ev.partial_reg_stall);
    endproperty
    a_partial: assert property (p_partial) else $error("partial stall count wrong");

    property p_read_port_idle;
        @(posedge ref_clk) disable iff (!rstn)
        hit(sel, CESD_EV_RENAME, CESD_UM_04) && !ev.read_port_stall |=> !increment;
    endproperty
    a_read_port_idle: assert property (p_read_port_idle) else $error("stray read stall");

    property p_serial;
        @(posedge ref_clk) disable iff (!rstn)
        hit(sel, CESD_EV_RENAME, CESD_UM_08) |=> increment == $past(ev.serialization_stall);
    endproperty
    a_serial: assert property (p_serial) else $error("serialization count wrong");

    property p_fpsw_in_any;
        @(posedge ref_clk) disable iff (!rstn)
        hit(sel, CESD_EV_RENAME, CESD_UM_0F) && ev.fp_status_word_stall |=> increment;
    endproperty
    a_fpsw_in_any: assert property (p_fpsw_in_any) else $error("status stall missed");

    property p_seg_idle;
        @(posedge ref_clk) disable iff (!rstn)
        hit(sel, CESD_EV_SEG_STALL, CESD_UM_01) && !ev.segment_rename_stall |=> !increment;
    endproperty
    a_seg_idle: assert property (p_seg_idle) else $error("stray segment stall");

    property p_es_rename;
        @(posedge ref_clk) disable iff (!rstn)
        hit(sel, CESD_EV_ES_RENAME, CESD_UM_01) |=> increment == $past(ev.extra_segment_rename);
    endproperty
    a_es_rename: assert property (p_es_rename) else $error("rename count wrong");

    property p_unlisted_pair;
        @(posedge ref_clk) disable iff (!rstn)
        !pair_listed(sel) |=> !increment;
    endproperty
    a_unlisted_pair: assert property (p_unlisted_pair) else $error("pair counted");

endmodule // cesd_selector

// file: cesd_core_model.sv
`timescale 1ns/1ps
module cesd_core_model (
    input wire logic rstn,
    input wire cesd_pkg::cesd_events_t req,
    output cesd_pkg::cesd_events_t ev
);
    import cesd_pkg::*;
    // front end stays quiet while the core is held in reset
    assign ev = rstn ? req : '0;
endmodule // cesd_core_model

// file: tb.sv
`timescale 1ns/1ps
module tb;
    import cesd_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    cesd_select_t sel = '0;
    cesd_events_t req = '0;
    cesd_events_t ev;
    logic increment;
    int err_count = 0;
    int num_checks = 0;
    logic [7:0] t_code [10] = '{8'hD0, 8'hD1, 8'hD1, 8'hD1, 8'hD2, 8'hD2, 8'hD2, 8'hD2,
        8'hD4, 8'hD5};
    logic [7:0] t_mask [10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h01, 8'h02, 8'h04, 8'h08,
        8'h01, 8'h01};
    int t_bit [10] = '{10, 9, 8, 7, 6, 5, 4, 3, 1, 0};
    always #10 ref_clk = ~ref_clk;
    cesd_core_model i_model (.rstn(rstn), .req(req), .ev(ev));
    cesd_selector i_dut (.ref_clk(ref_clk), .rstn(rstn), .sel(sel), .ev(ev),
        .increment(increment));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic got, input logic exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask
    // present one cycle of occurrences, judge the registered answer a cycle on
    task automatic step(input logic [12:0] bits, input logic exp, input string what);
        req = cesd_events_t'(bits);
        @(negedge ref_clk);
        check(increment, exp, what);
    endtask
    task automatic put_sel(input logic [7:0] code, input logic [7:0] mask);
        sel = '{event_code: code, unit_mask: mask};
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // kinds bit high means float, low means simd; oldest first
    task automatic trans(input logic [7:0] mask, input logic [3:0] kinds,
        input logic [3:0] exp);
        put_sel(CESD_EV_FP_SIMD, mask);
        for (int i = 3; i >= 0; i--) begin
            step(kinds[i] ? 13'h1000 : 13'h0800, exp[i], "transition");
        end
    endtask
    task automatic run_transitions;
        trans(CESD_UM_03, 4'b1001, 4'b0101);
        trans(CESD_UM_01, 4'b0110, 4'b0100);
        trans(CESD_UM_02, 4'b1001, 4'b0100);
        put_sel(CESD_EV_FP_SIMD, CESD_UM_02);
        step(13'h1800, 1'b1, "both kinds");
        put_sel(CESD_EV_FP_SIMD, CESD_UM_01);
        step(13'h1800, 1'b0, "both kinds float");
        step(13'h1000, 1'b1, "float after both");
        put_sel(CESD_EV_FP_SIMD, CESD_UM_03);
        step(13'h1800, 1'b1, "both kinds any");
        step(13'h0000, 1'b0, "idle");
    endtask
    task automatic run_singles;
        logic [12:0] one;
        for (int k = 0; k < 10; k++) begin
            one = 13'h0001 << t_bit[k];
            put_sel(t_code[k], t_mask[k]);
            step(one, 1'b1, "single first");
            step(one, 1'b1, "single repeat");
            step(~one & 13'h07FF, 1'b0, "single others");
        end
    endtask
    task automatic run_any_stall;
        put_sel(CESD_EV_RENAME, CESD_UM_0F);
        step(13'h0040, 1'b1, "any flag");
        step(13'h0020, 1'b1, "any partial");
        step(13'h0010, 1'b1, "any read port");
        step(13'h0004, 1'b1, "any fp status");
        step(13'h0008, 1'b0, "any serialization");
        step(13'h0000, 1'b0, "any idle");
    endtask
    task automatic run_unlisted;
        put_sel(CESD_EV_FP_SIMD, CESD_UM_04);
        step(13'h1FFF, 1'b0, "unlisted mask");
        put_sel(8'hD3, CESD_UM_01);
        step(13'h0800, 1'b0, "unlisted code");
        put_sel(CESD_EV_RENAME, 8'h10);
        step(13'h1FFF, 1'b0, "unlisted stall mask");
        step(13'h0000, 1'b0, "unlisted idle");
    endtask
    // mid-run reset must clear the float/simd history
    task automatic run_reset;
        put_sel(CESD_EV_FP_SIMD, CESD_UM_01);
        step(13'h0800, 1'b0, "before reset");
        rstn = 1'b0;
        step(13'h1000, 1'b0, "in reset");
        rstn = 1'b1;
        step(13'h1000, 1'b0, "first after reset");
        step(13'h0800, 1'b0, "simd after reset");
        step(13'h1000, 1'b1, "float after reset");
    endtask
    initial begin
        repeat (16) @(negedge ref_clk);
        rstn = 1'b1;
        run_transitions();
        run_singles();
        run_any_stall();
        run_unlisted();
        run_reset();
        stop_test();
    end
endmodule // tb
